// ==== hdl/tcrb_pkg.sv ====
// ----------------------------------------------------------------------------
// shared constants and types of the third timer
// ----------------------------------------------------------------------------
package tcrb_pkg;

  // --------------------------------------------------------------------------
  // special function register addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] TCRB_ADDR_CLOCK_SPEED_CONTROL = 8'h8e;
  localparam logic [7:0] TCRB_ADDR_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] TCRB_ADDR_RELOAD_CAPTURE_LOW = 8'hca;
  localparam logic [7:0] TCRB_ADDR_RELOAD_CAPTURE_HIGH = 8'hcb;
  localparam logic [7:0] TCRB_ADDR_COUNTER_LOW_BYTE = 8'hcc;
  localparam logic [7:0] TCRB_ADDR_COUNTER_HIGH_BYTE = 8'hcd;

  // --------------------------------------------------------------------------
  // values after reset
  // --------------------------------------------------------------------------
  localparam logic [7:0] TCRB_RST_CLOCK_SPEED_CONTROL = 8'h01;
  localparam logic [7:0] TCRB_RST_TIMER_CONTROL = 8'h00;
  localparam logic [15:0] TCRB_RST_RELOAD_CAPTURE = 16'h0000;
  localparam logic [15:0] TCRB_RST_COUNTER = 16'h0000;
  localparam logic [7:0] TCRB_RST_READ_DATA = 8'h00;
  localparam logic TCRB_RST_PIN_LEVEL = 1'b1;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int TCRB_FAST_DIVIDE_BIT = 5;

  // --------------------------------------------------------------------------
  // clocks per tick and counter limits
  // --------------------------------------------------------------------------
  localparam logic [3:0] TCRB_DIV_SLOW = 4'hc;
  localparam logic [3:0] TCRB_DIV_FAST = 4'h4;
  localparam logic [3:0] TCRB_DIV_BAUD = 4'h2;
  localparam logic [3:0] TCRB_PRESC_ZERO = 4'h0;
  localparam logic [15:0] TCRB_COUNT_MAX = 16'hffff;
  localparam logic [15:0] TCRB_COUNT_ONE = 16'h0001;

  // timer control register layout, bit 7 first
  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic ext_edge_enable;
    logic run_control;
    logic count_source_select;
    logic capture_not_reload;
  } tcrb_ctrl_t;

  // one register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tcrb_sfr_req_t;

  // the two timer pins, already synchronous to the clock
  typedef struct packed {
    logic ext_count_pin;
    logic ext_trigger_pin;
  } tcrb_pins_t;

  // state of a falling edge detector
  typedef struct packed {
    logic prev;
    logic fall;
  } tcrb_fall_state_t;

  // state of the timer
  typedef struct packed {
    tcrb_ctrl_t ctrl;
    logic [7:0] clock_speed_control;
    logic [15:0] reload_capture;
    logic [15:0] counter;
    logic [3:0] presc;
    logic [7:0] rdata;
    logic irq;
    logic tx_tick;
    logic rx_tick;
  } tcrb_state_t;

endpackage

// ==== hdl/tcrb_fall.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// falling edge detector, one registered pulse per high-to-low transition
// ----------------------------------------------------------------------------
module tcrb_fall (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // pin level
  input wire logic pin,
  // one-cycle pulse
  output logic fall
);
  import tcrb_pkg::*;

  tcrb_fall_state_t st_ff;
  tcrb_fall_state_t nxt_st;

  // pin idles high after reset so no false edge is seen
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = pin;
    nxt_st.fall = st_ff.prev & ~pin;
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{prev: TCRB_RST_PIN_LEVEL, fall: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall = st_ff.fall;

endmodule
`default_nettype wire

// ==== hdl/tcrb_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcrb_timer (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // special function register access
  input wire tcrb_pkg::tcrb_sfr_req_t SFR_REQ,
  output var logic [7:0] SFR_RDATA,
  // timer pins
  input wire tcrb_pkg::tcrb_pins_t PINS,
  // interrupt and serial port shift clocks
  output var logic TIMER_IRQ,
  output var logic BAUD_TX_TICK,
  output var logic BAUD_RX_TICK
);
  import tcrb_pkg::*;

  tcrb_state_t st_ff;
  tcrb_state_t nxt_st;
  logic count_fall;
  logic trig_fall;
  logic baud_mode;
  logic presc_tick;
  logic advance;
  logic rollover;
  logic trig_event;
  logic [3:0] divisor;

  // --------------------------------------------------------------------------
  // pin edge detection
  // --------------------------------------------------------------------------
  tcrb_fall u_count_fall (
    .clk_sys(CLK_SYS),
    .reset_n(RESET_N),
    .pin(PINS.ext_count_pin),
    .fall(count_fall)
  );

  tcrb_fall u_trig_fall (
    .clk_sys(CLK_SYS),
    .reset_n(RESET_N),
    .pin(PINS.ext_trigger_pin),
    .fall(trig_fall)
  );

  // address match used by read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // --------------------------------------------------------------------------
  // mode and tick decode
  // --------------------------------------------------------------------------
  always_comb begin
    baud_mode = st_ff.ctrl.rx_baud_select | st_ff.ctrl.tx_baud_select;
    if (baud_mode) begin
      divisor = TCRB_DIV_BAUD;
    end else if (st_ff.clock_speed_control[TCRB_FAST_DIVIDE_BIT]) begin
      divisor = TCRB_DIV_FAST;
    end else begin
      divisor = TCRB_DIV_SLOW;
    end
    presc_tick = (st_ff.presc == divisor - 4'h1);
    // source select picks clock ticks or count pin falls
    advance = st_ff.ctrl.run_control &&
              (st_ff.ctrl.count_source_select ? count_fall : presc_tick);
    rollover = advance && (st_ff.counter == TCRB_COUNT_MAX);
    trig_event = trig_fall && st_ff.ctrl.ext_edge_enable;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_tick = 1'b0;
    nxt_st.rx_tick = 1'b0;
    nxt_st.rdata = TCRB_RST_READ_DATA;

    // prescaler runs whenever run_control is set, whichever count source is selected
    if (!st_ff.ctrl.run_control || presc_tick || st_ff.presc >= divisor) begin
      nxt_st.presc = TCRB_PRESC_ZERO;
    end else begin
      nxt_st.presc = st_ff.presc + 4'h1;
    end

    // software writes first so hardware flag sets win below
    if (SFR_REQ.wr) begin
      if (hit(SFR_REQ.addr, TCRB_ADDR_CLOCK_SPEED_CONTROL)) begin
        nxt_st.clock_speed_control = SFR_REQ.wdata;
      end
      if (hit(SFR_REQ.addr, TCRB_ADDR_TIMER_CONTROL)) begin
        nxt_st.ctrl = tcrb_ctrl_t'(SFR_REQ.wdata);
      end
      if (hit(SFR_REQ.addr, TCRB_ADDR_RELOAD_CAPTURE_LOW)) begin
        nxt_st.reload_capture[7:0] = SFR_REQ.wdata;
      end
      if (hit(SFR_REQ.addr, TCRB_ADDR_RELOAD_CAPTURE_HIGH)) begin
        nxt_st.reload_capture[15:8] = SFR_REQ.wdata;
      end
    end

    // counting, always upward
    if (advance) begin
      nxt_st.counter = st_ff.counter + TCRB_COUNT_ONE;
    end

    if (baud_mode) begin
      // auto-reload regardless of capture_not_reload
      if (rollover) begin
        nxt_st.counter = st_ff.reload_capture;
        nxt_st.tx_tick = st_ff.ctrl.tx_baud_select;
        nxt_st.rx_tick = st_ff.ctrl.rx_baud_select;
      end
      if (trig_event) begin
        nxt_st.ctrl.external_event_flag = 1'b1;
      end
    end else if (st_ff.ctrl.capture_not_reload) begin
      if (rollover) begin
        nxt_st.ctrl.overflow_flag = 1'b1;
      end
      if (trig_event) begin
        nxt_st.reload_capture = st_ff.counter;
        nxt_st.ctrl.external_event_flag = 1'b1;
      end
    end else begin
      if (rollover) begin
        nxt_st.ctrl.overflow_flag = 1'b1;
        nxt_st.counter = st_ff.reload_capture;
      end
      if (trig_event) begin
        nxt_st.counter = st_ff.reload_capture;
        nxt_st.ctrl.external_event_flag = 1'b1;
      end
    end

    // software counter writes override counting in the same cycle
    if (SFR_REQ.wr && hit(SFR_REQ.addr, TCRB_ADDR_COUNTER_LOW_BYTE)) begin
      nxt_st.counter[7:0] = SFR_REQ.wdata;
    end
    if (SFR_REQ.wr && hit(SFR_REQ.addr, TCRB_ADDR_COUNTER_HIGH_BYTE)) begin
      nxt_st.counter[15:8] = SFR_REQ.wdata;
    end

    // interrupt request is the OR of both flags
    nxt_st.irq = nxt_st.ctrl.overflow_flag | nxt_st.ctrl.external_event_flag;

    // registered read data, zero for unmapped addresses
    if (SFR_REQ.rd) begin
      if (hit(SFR_REQ.addr, TCRB_ADDR_CLOCK_SPEED_CONTROL)) begin
        nxt_st.rdata = st_ff.clock_speed_control;
      end else if (hit(SFR_REQ.addr, TCRB_ADDR_TIMER_CONTROL)) begin
        nxt_st.rdata = st_ff.ctrl;
      end else if (hit(SFR_REQ.addr, TCRB_ADDR_RELOAD_CAPTURE_LOW)) begin
        nxt_st.rdata = st_ff.reload_capture[7:0];
      end else if (hit(SFR_REQ.addr, TCRB_ADDR_RELOAD_CAPTURE_HIGH)) begin
        nxt_st.rdata = st_ff.reload_capture[15:8];
      end else if (hit(SFR_REQ.addr, TCRB_ADDR_COUNTER_LOW_BYTE)) begin
        nxt_st.rdata = st_ff.counter[7:0];
      end else if (hit(SFR_REQ.addr, TCRB_ADDR_COUNTER_HIGH_BYTE)) begin
        nxt_st.rdata = st_ff.counter[15:8];
      end else begin
        nxt_st.rdata = TCRB_RST_READ_DATA;
      end
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff.ctrl <= tcrb_ctrl_t'(TCRB_RST_TIMER_CONTROL);
      st_ff.clock_speed_control <= TCRB_RST_CLOCK_SPEED_CONTROL;
      st_ff.reload_capture <= TCRB_RST_RELOAD_CAPTURE;
      st_ff.counter <= TCRB_RST_COUNTER;
      st_ff.presc <= TCRB_PRESC_ZERO;
      st_ff.rdata <= TCRB_RST_READ_DATA;
      st_ff.irq <= 1'b0;
      st_ff.tx_tick <= 1'b0;
      st_ff.rx_tick <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign SFR_RDATA = st_ff.rdata;
  assign TIMER_IRQ = st_ff.irq;
  assign BAUD_TX_TICK = st_ff.tx_tick;
  assign BAUD_RX_TICK = st_ff.rx_tick;

endmodule
`default_nettype wire

// ==== test/tcrb_timer_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker of the third timer
// ----------------------------------------
module tcrb_timer_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // register bus
  input wire tcrb_pkg::tcrb_sfr_req_t SFR_REQ,
  input wire logic [7:0] SFR_RDATA,
  // pins and events
  input wire tcrb_pkg::tcrb_pins_t PINS,
  input wire logic TIMER_IRQ,
  input wire logic BAUD_TX_TICK,
  input wire logic BAUD_RX_TICK
);
  import tcrb_pkg::*;
  logic [7:0] ctl_ff, ck_ff;
  logic [3:0] hist_ff;
  logic prev_ff, wr_ctl, mapped;
  // decoded bus events
  assign wr_ctl = SFR_REQ.wr && SFR_REQ.addr == TCRB_ADDR_TIMER_CONTROL;
  assign mapped = SFR_REQ.addr inside {8'h8e, 8'hc8, [8'hca:8'hcd]};
  // software copies of control bits and a short history of trigger falls
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctl_ff <= 8'h00;
      ck_ff <= 8'h01;
      hist_ff <= 4'h0;
      prev_ff <= 1'b1;
    end else begin
      if (wr_ctl) ctl_ff <= SFR_REQ.wdata;
      if (SFR_REQ.wr && SFR_REQ.addr == 8'h8e) ck_ff <= SFR_REQ.wdata;
      hist_ff <= {hist_ff[2:0], prev_ff & ~PINS.ext_trigger_pin};
      prev_ff <= PINS.ext_trigger_pin;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // clean read of one address
  sequence s_rd(a);
    SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == a;
  endsequence
  property p_rd_idle;
    !SFR_REQ.rd |=> SFR_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    SFR_REQ.rd && !mapped |=> SFR_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctl_read;
    s_rd(TCRB_ADDR_TIMER_CONTROL) |=> SFR_RDATA[5:0] == $past(ctl_ff[5:0]);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");
  property p_ck_read;
    s_rd(TCRB_ADDR_CLOCK_SPEED_CONTROL) |=> SFR_RDATA == $past(ck_ff);
  endproperty
  a_ck_read: assert property (p_ck_read) else $error("speed read wrong");
  property p_tick_one;
    BAUD_TX_TICK || BAUD_RX_TICK |=> !(BAUD_TX_TICK || BAUD_RX_TICK);
  endproperty
  a_tick_one: assert property (p_tick_one) else $error("tick too long");
  property p_tick_mode;
    BAUD_TX_TICK |-> ctl_ff[4] || $past(ctl_ff[4]);
  endproperty
  a_tick_mode: assert property (p_tick_mode) else $error("tick outside baud");
  property p_rx_mode;
    BAUD_RX_TICK |-> ctl_ff[5] || $past(ctl_ff[5]);
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("rx tick outside baud");
  property p_irq_fall;
    $fell(TIMER_IRQ) |-> $past(wr_ctl) || $past(wr_ctl, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_baud_irq;
    $rose(TIMER_IRQ) && ctl_ff[5:4] != 2'b00 |-> hist_ff != 4'h0 || $past(wr_ctl);
  endproperty
  a_baud_irq: assert property (p_baud_irq) else $error("baud irq no cause");
endmodule
bind tcrb_timer tcrb_timer_checker u_chk (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .PINS(PINS),
  .TIMER_IRQ(TIMER_IRQ), .BAUD_TX_TICK(BAUD_TX_TICK), .BAUD_RX_TICK(BAUD_RX_TICK));
`default_nettype wire

// ==== test/tcrb_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// processor core side of the register bus
// ----------------------------------------
module tcrb_core_model (
  // clock
  input wire logic CLK_SYS,
  // register bus
  output var tcrb_pkg::tcrb_sfr_req_t SFR_REQ,
  input wire logic [7:0] SFR_RDATA
);
  import tcrb_pkg::*;
  initial SFR_REQ = '0;
  // one write, strobe held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    SFR_REQ = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge CLK_SYS);
    SFR_REQ.wr = 1'b0;
  endtask
  // one read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK_SYS);
    SFR_REQ = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge CLK_SYS);
    SFR_REQ.rd = 1'b0;
    d = SFR_RDATA;
  endtask
endmodule
`default_nettype wire

// ==== test/timer_two_capture_reload_baud_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// self-checking bench of the third timer
// ----------------------------------------
module timer_two_capture_reload_baud_tb_top;
  import tcrb_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, irq, tx_tick, rx_tick;
  tcrb_sfr_req_t sfr_req;
  tcrb_pins_t pins = 2'b11;
  logic [7:0] rdata;
  logic [31:0] lfsr = 32'h16158;
  logic [7:0] adr[8] = '{8'h8e, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9, 8'hce};
  int bad_count = 0, check_count = 0, tx_n = 0, rx_n = 0;
  // clock and tick counters
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tx_n <= tx_n + int'(tx_tick);
    rx_n <= rx_n + int'(rx_tick);
  end
  tcrb_timer u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SFR_REQ(sfr_req), .SFR_RDATA(rdata),
    .PINS(pins), .TIMER_IRQ(irq), .BAUD_TX_TICK(tx_tick), .BAUD_RX_TICK(rx_tick));
  tcrb_core_model u_core (.CLK_SYS(clk_sys), .SFR_REQ(sfr_req), .SFR_RDATA(rdata));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  // shift ticks in a span when reloading from rl at two clocks a count
  function automatic int n_ticks(int clocks, logic [15:0] rl);
    return clocks / (2 * (17'h10000 - rl));
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    u_core.wr(a, v[7:0]);
    u_core.wr(a + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    u_core.rd(a, v[7:0]);
    u_core.rd(a + 8'h01, v[15:8]);
  endtask
  // one falling edge on the trigger or the count pin
  task automatic pin_fall(input bit trig);
    @(negedge clk_sys);
    if (trig) pins.ext_trigger_pin = 1'b0;
    else pins.ext_count_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
    pins = 2'b11;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic conclude();
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
  // main sequence
  initial begin
    logic [15:0] v, r, y;
    int n, m;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1'b1;
    foreach (adr[i]) begin
      u_core.rd(adr[i], v[7:0]);
      chk("reset", {8'h00, v[7:0]}, i == 0 ? 16'h0001 : 16'h0000);
    end
    v = rnd();
    wr16(8'hcc, v);
    repeat (30) @(negedge clk_sys);
    rd16(8'hcc, r);
    chk("held", r, v);
    for (int f = 0; f < 2; f++) begin
      wr16(8'hca, 16'h1234);
      u_core.wr(8'h8e, {2'b00, f[0], 5'h01});
      wr16(8'hcc, 16'hfff8);
      u_core.wr(8'hc8, 8'h05);
      repeat (f ? 36 : 116) @(negedge clk_sys);
      u_core.rd(8'hc8, v[7:0]);
      chk("ctl", {8'h00, v[7:0]}, 16'h0085);
      chk("irq", {15'h0, irq}, 16'h0001);
      u_core.wr(8'hc8, 8'h00);
      chk("irq clr", {15'h0, irq}, 16'h0000);
      rd16(8'hcc, r);
      chk("wrap", {15'h0, r >= 1 && r <= 3}, 16'h0001);
    end
    v = rnd() & 16'h7fff;
    wr16(8'hca, v);
    wr16(8'hcc, 16'hfff8);
    u_core.wr(8'hc8, 8'h04);
    repeat (36) @(negedge clk_sys);
    u_core.wr(8'hc8, 8'h80);
    rd16(8'hcc, r);
    chk("reload", {15'h0, r - v >= 1 && r - v <= 3}, 16'h0001);
    for (int e = 0; e < 2; e++) begin
      y = rnd();
      v = rnd();
      wr16(8'hca, y);
      wr16(8'hcc, v);
      u_core.wr(8'hc8, {4'h0, e[0], 3'h0});
      pin_fall(1'b1);
      rd16(8'hcc, r);
      chk("forced", r, e ? y : v);
    end
    // fresh count so the capture visibly replaces the reload value
    wr16(8'hcc, v);
    u_core.wr(8'hc8, 8'h09);
    pin_fall(1'b1);
    rd16(8'hca, r);
    chk("capture", r, v);
    u_core.rd(8'hc8, v[7:0]);
    chk("event", {8'h00, v[7:0]}, 16'h0049);
    wr16(8'hca, 16'hfffc);
    wr16(8'hcc, 16'hfffc);
    u_core.wr(8'hc8, 8'h3d);
    n = tx_n;
    m = rx_n;
    repeat (80) @(negedge clk_sys);
    // tick counts within one of the expected number, both ways
    chk("tx", {15'h0, unsigned'(tx_n - n - n_ticks(80, 16'hfffc) + 1) <= 2}, 16'h0001);
    chk("rx", {15'h0, unsigned'(rx_n - m - n_ticks(80, 16'hfffc) + 1) <= 2}, 16'h0001);
    chk("no ovf", {15'h0, irq}, 16'h0000);
    pin_fall(1'b1);
    chk("baud evt", {15'h0, irq}, 16'h0001);
    // stop baud counting before the counter is preloaded
    u_core.wr(8'hc8, 8'h02);
    wr16(8'hcc, 16'h0000);
    u_core.wr(8'hc8, 8'h06);
    repeat (5) pin_fall(1'b0);
    u_core.wr(8'hc8, 8'h00);
    rd16(8'hcc, r);
    chk("pin count", r, 16'h0005);
    // second reset in mid-run brings the registers back
    @(negedge clk_sys) reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    rd16(8'hcc, r);
    chk("reset count", r, 16'h0000);
    u_core.rd(8'h8e, v[7:0]);
    chk("reset speed", {8'h00, v[7:0]}, 16'h0001);
    conclude();
  end
endmodule
`default_nettype wire
